// ===== hdl/cpo_delay_timer.sv
// Down-counting delay timer for the on-delay and the off-delay.
`timescale 1ns/1ns
`default_nettype none
module cpo_delay_timer
    import cpo_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Sequencer side.
    cpo_timer_if.timer tmr
);

    typedef struct packed {
        logic busy;
        logic [CNT_W-1:0] count;
    } cpo_tmr_regs_t;

    localparam cpo_tmr_regs_t TMR_RESET = '{default: '0};

    cpo_tmr_regs_t r_reg;
    cpo_tmr_regs_t r_next;

    ////////////////////////////////////////////////////////////////////////////
    // Done marks the last cycle of a running count. It is kept free of the start and
    // abort inputs, since the sequencer reads it in the process that drives them.
    assign tmr.busy = r_reg.busy;
    assign tmr.done = r_reg.busy && (r_reg.count == CNT_ONE);

    // Abort beats a start, and a start reloads a running count.
    always_comb begin
        r_next = r_reg;
        if (tmr.abort) begin
            r_next.busy = 1'b0;
        end else if (tmr.start) begin
            r_next.busy = 1'b1;
            r_next.count = tmr.load;
        end else if (r_reg.busy) begin
            if (r_reg.count == CNT_ONE) begin
                r_next.busy = 1'b0;
            end else begin
                r_next.count = r_reg.count - CNT_ONE;
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            r_reg <= TMR_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The count falls by exactly one per cycle while nothing interrupts it.
    property p_count_down;
        @(posedge i_clock) disable iff (!i_rst_b)
        (r_reg.busy && !tmr.start && !tmr.abort && r_reg.count > CNT_ONE)
            |=> (r_reg.busy && r_reg.count == $past(r_reg.count) - CNT_ONE);
    endproperty
    a_count_down: assert property (p_count_down) else $error("timer count slipped");

endmodule
`default_nettype wire

// ===== hdl/cpo_pkg.sv
// Package with constants and types for the channel A power-on control block.
package cpo_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and delay times. The delays are typical values, taken as exact.
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned T_DLY_0MS_NS = 0;
    localparam int unsigned T_DLY_50MS_NS = 50_000_000;
    localparam int unsigned T_DLY_250MS_NS = 250_000_000;
    localparam int unsigned T_DLY_1S_NS = 1_000_000_000;
    // A zero delay still costs one timer cycle, since no count may be below one.
    localparam int unsigned CYC_DLY_0MS =
        (T_DLY_0MS_NS / CLK_PERIOD_NS > 0) ? T_DLY_0MS_NS / CLK_PERIOD_NS : 1;
    localparam int unsigned CYC_DLY_50MS = T_DLY_50MS_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_DLY_250MS = T_DLY_250MS_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_DLY_1S = T_DLY_1S_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

    ////////////////////////////////////////////////////////////////////////////
    // Register map. Printed offsets are word indices; byte address is four times.
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_SETTING = 16'hFE79;
    localparam logic [15:0] IDX_STATUS = 16'h0001;
    localparam logic [7:0] SETTING_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Setting register fields.
    localparam int BIT_POLARITY = 7;
    localparam int BIT_SW_REQUEST = 6;
    localparam int SEL_HI = 5;
    localparam int SEL_LO = 4;
    localparam int ON_DLY_HI = 3;
    localparam int ON_DLY_LO = 2;
    localparam int OFF_DLY_HI = 1;
    localparam int OFF_DLY_LO = 0;

    // Status register fields.
    localparam int ST_PIN = 0;
    localparam int ST_REQUEST = 1;
    localparam int ST_ENABLE = 2;
    localparam int ST_PENDING = 3;

    // Request source selection codes.
    localparam logic [1:0] SEL_ALWAYS_ON = 2'h0;
    localparam logic [1:0] SEL_PIN = 2'h1;
    localparam logic [1:0] SEL_SOFTWARE = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;

    // Delay codes shared by the on-delay and the off-delay fields.
    localparam logic [1:0] DLY_0MS = 2'h0;
    localparam logic [1:0] DLY_50MS = 2'h1;
    localparam logic [1:0] DLY_250MS = 2'h2;
    localparam logic [1:0] DLY_1S = 2'h3;

    // Channel sequencing states.
    typedef enum logic [1:0] {CPO_OFF, CPO_ON_WAIT, CPO_ON, CPO_OFF_WAIT} cpo_state_t;

endpackage

// ===== hdl/cpo_power_on_ctrl.sv
// Channel A power-on control: request selection, on/off delays, AXI4-Lite registers.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module cpo_power_on_ctrl
    import cpo_pkg::*;
#(
    parameter int unsigned P_DLY_50MS_CYCLES = CYC_DLY_50MS,
    parameter int unsigned P_DLY_250MS_CYCLES = CYC_DLY_250MS,
    parameter int unsigned P_DLY_1S_CYCLES = CYC_DLY_1S
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    // AXI4-Lite read address and data.
    input wire logic [ADDR_W-1:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    // Request pin from the host and channel enable to the soft-start logic.
    input wire logic i_channel_a_power_on_request,
    output logic o_channel_a_enable
);

    typedef struct packed {
        logic [1:0] pin_sync;
        logic [7:0] setting;
        cpo_state_t state;
        logic enable;
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } cpo_regs_t;

    localparam cpo_regs_t REGS_RESET = '{setting: SETTING_RESET, state: CPO_OFF, default: '0};

    cpo_regs_t r_reg;
    cpo_regs_t r_next;
    cpo_timer_if tmr_if ();

    logic pin_level;
    logic sw_request;
    logic [1:0] source_sel;
    logic [1:0] on_code;
    logic [1:0] channel_a_power_off_delay;
    logic pin_request;
    logic eff_req;

    ////////////////////////////////////////////////////////////////////////////
    // Maps a delay code to a cycle count; parameters allow a short simulation.
    function automatic logic [CNT_W-1:0] dly_cycles(input logic [1:0] code);
        logic [CNT_W-1:0] cyc;
        cyc = CNT_W'(CYC_DLY_0MS);
        case (code)
            DLY_50MS: cyc = CNT_W'(P_DLY_50MS_CYCLES);
            DLY_250MS: cyc = CNT_W'(P_DLY_250MS_CYCLES);
            DLY_1S: cyc = CNT_W'(P_DLY_1S_CYCLES);
            default: cyc = CNT_W'(CYC_DLY_0MS);
        endcase
        return cyc;
    endfunction

    // Field views of the setting register and the synchronised pin.
    assign pin_level = r_reg.pin_sync[1];
    assign sw_request = r_reg.setting[BIT_SW_REQUEST];
    assign source_sel = r_reg.setting[SEL_HI:SEL_LO];
    assign on_code = r_reg.setting[ON_DLY_HI:ON_DLY_LO];
    assign channel_a_power_off_delay = r_reg.setting[OFF_DLY_HI:OFF_DLY_LO];
    assign pin_request = pin_level ^ r_reg.setting[BIT_POLARITY];

    // Effective request. Polarity only reaches the pin-based sources.
    always_comb begin
        case (source_sel)
            SEL_ALWAYS_ON: eff_req = 1'b1;
            SEL_PIN: eff_req = pin_request;
            SEL_SOFTWARE: eff_req = sw_request;
            SEL_BOTH: eff_req = pin_request && sw_request;
            default: eff_req = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready signals: one held address and one held data word at a time.
    assign o_axi_awready = !r_reg.aw_full;
    assign o_axi_wready = !r_reg.w_full;
    assign o_axi_arready = !r_reg.rvalid;
    assign o_axi_bvalid = r_reg.bvalid;
    assign o_axi_bresp = r_reg.bresp;
    assign o_axi_rvalid = r_reg.rvalid;
    assign o_axi_rresp = r_reg.rresp;
    assign o_axi_rdata = r_reg.rdata;
    assign o_channel_a_enable = r_reg.enable;

    // Next state: pin synchroniser, bus slave and channel sequencer.
    always_comb begin
        r_next = r_reg;
        tmr_if.start = 1'b0;
        tmr_if.abort = 1'b0;
        tmr_if.load = dly_cycles(on_code);
        // The pin is asynchronous to this clock, so it passes two flops first.
        r_next.pin_sync = {r_reg.pin_sync[0], i_channel_a_power_on_request};

        // Write channel: address and data may arrive in either order.
        if (i_axi_awvalid && !r_reg.aw_full) begin
            r_next.aw_full = 1'b1;
            r_next.aw_addr = i_axi_awaddr;
        end
        if (i_axi_wvalid && !r_reg.w_full) begin
            r_next.w_full = 1'b1;
            r_next.w_data = i_axi_wdata;
            r_next.w_strb = i_axi_wstrb;
        end
        if (r_reg.bvalid && i_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        // The write completes only once the previous response has been taken.
        if (r_reg.aw_full && r_reg.w_full && !r_reg.bvalid) begin
            r_next.aw_full = 1'b0;
            r_next.w_full = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = RESP_OKAY;
            if (r_reg.aw_addr[ADDR_W-1:2] == IDX_SETTING) begin
                if (r_reg.w_strb[0]) begin
                    r_next.setting = r_reg.w_data[7:0];
                end
            end else if (r_reg.aw_addr[ADDR_W-1:2] != IDX_STATUS) begin
                r_next.bresp = RESP_SLVERR;
            end
        end

        // Read channel: data is registered one cycle after the address.
        if (r_reg.rvalid && i_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (i_axi_arvalid && !r_reg.rvalid) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = RESP_OKAY;
            r_next.rdata = '0;
            if (i_axi_araddr[ADDR_W-1:2] == IDX_SETTING) begin
                r_next.rdata[7:0] = r_reg.setting;
            end else if (i_axi_araddr[ADDR_W-1:2] == IDX_STATUS) begin
                r_next.rdata[ST_PIN] = pin_level;
                r_next.rdata[ST_REQUEST] = eff_req;
                r_next.rdata[ST_ENABLE] = r_reg.enable;
                r_next.rdata[ST_PENDING] = tmr_if.busy;
            end else begin
                r_next.rresp = RESP_SLVERR;
            end
        end

        // Sequencer. A request change during a wait cancels the wait at once.
        case (r_reg.state)
            CPO_OFF: begin
                if (eff_req) begin
                    r_next.state = CPO_ON_WAIT;
                    tmr_if.start = 1'b1;
                end
            end
            CPO_ON_WAIT: begin
                if (!eff_req) begin
                    r_next.state = CPO_OFF;
                    tmr_if.abort = 1'b1;
                end else if (tmr_if.done) begin
                    r_next.state = CPO_ON;
                    r_next.enable = 1'b1;
                end
            end
            CPO_ON: begin
                if (!eff_req) begin
                    r_next.state = CPO_OFF_WAIT;
                    tmr_if.start = 1'b1;
                    tmr_if.load = dly_cycles(channel_a_power_off_delay);
                end
            end
            CPO_OFF_WAIT: begin
                if (eff_req) begin
                    r_next.state = CPO_ON;
                    tmr_if.abort = 1'b1;
                end else if (tmr_if.done) begin
                    r_next.state = CPO_OFF;
                    r_next.enable = 1'b0;
                end
            end
            default: begin
                r_next.state = CPO_OFF;
                r_next.enable = 1'b0;
                tmr_if.abort = 1'b1;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            r_reg <= REGS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One timer serves both delays; only one of them can be pending at a time.
    cpo_delay_timer u_timer (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .tmr (tmr_if.timer)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks on request selection and sequencing.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    property p_always_on;
        (source_sel == SEL_ALWAYS_ON) |-> eff_req;
    endproperty
    a_always_on: assert property (p_always_on) else $error("always-on source not requesting");

    property p_pin_only;
        (source_sel == SEL_PIN) |-> (eff_req == (r_reg.pin_sync[1] ^ r_reg.setting[BIT_POLARITY]));
    endproperty
    a_pin_only: assert property (p_pin_only) else $error("pin source request mismatch");

    property p_polarity;
        (source_sel == SEL_PIN && r_reg.setting[BIT_POLARITY]) |-> (eff_req != pin_level);
    endproperty
    a_polarity: assert property (p_polarity) else $error("inverted pin polarity wrong");

    property p_sw_only;
        (source_sel == SEL_SOFTWARE) |-> (eff_req == sw_request);
    endproperty
    a_sw_only: assert property (p_sw_only) else $error("pin or polarity leaked into sw");

    property p_sw_needed;
        (source_sel[1] && !sw_request) |-> !eff_req;
    endproperty
    a_sw_needed: assert property (p_sw_needed) else $error("request without software bit");

    property p_both;
        (source_sel == SEL_BOTH) |-> (eff_req == (pin_request && sw_request));
    endproperty
    a_both: assert property (p_both) else $error("combined source mismatch");

    property p_on_zero;
        (r_reg.state == CPO_OFF && eff_req && on_code == DLY_0MS) ##1 eff_req |=> r_reg.enable;
    endproperty
    a_on_zero: assert property (p_on_zero) else $error("zero on-delay not two cycles");

    property p_off_zero;
        (r_reg.state == CPO_ON && !eff_req && channel_a_power_off_delay == DLY_0MS) ##1 !eff_req
            |=> !r_reg.enable;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("zero off-delay not two cycles");

    property p_abort;
        (r_reg.state == CPO_ON_WAIT && !eff_req) |=> (r_reg.state == CPO_OFF && !r_reg.enable);
    endproperty
    a_abort: assert property (p_abort) else $error("pending turn-on not abandoned");

    property p_enable_cause;
        $rose(r_reg.enable) |-> ($past(r_reg.state) == CPO_ON_WAIT && $past(eff_req));
    endproperty
    a_enable_cause: assert property (p_enable_cause) else $error("enable rose without delay");

    c_turn_on: cover property ($rose(r_reg.enable));
    c_turn_off: cover property ($fell(r_reg.enable));
    c_abort_on: cover property (r_reg.state == CPO_ON_WAIT ##1 r_reg.state == CPO_OFF);
    c_abort_off: cover property (r_reg.state == CPO_OFF_WAIT ##1 r_reg.state == CPO_ON);

endmodule
`default_nettype wire

// ===== hdl/cpo_timer_if.sv
// Interface between the channel sequencer and its delay timer.
`timescale 1ns/1ns
`default_nettype none
interface cpo_timer_if import cpo_pkg::*; ();
    logic start;
    logic abort;
    logic [CNT_W-1:0] load;
    logic done;
    logic busy;
    modport ctrl (output start, output abort, output load, input done, input busy);
    modport timer (input start, input abort, input load, output done, output busy);
endinterface
`default_nettype wire

// ===== sim/cpo_host_model.sv
// Host model that drives the channel A power-on request pin.
`timescale 1ns/1ns
`default_nettype none
module cpo_host_model (
    // Clock.
    input wire logic i_clock,
    // Commanded pin level and response speed.
    input wire logic i_level,
    input wire logic i_slow,
    // Request pin toward the block.
    output logic o_pin
);
    logic [2:0] stage_reg = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // The pin only moves just after a clock edge, one cycle after the command.
    // A slow host lags three more cycles, as a supervisor with its own filter would.
    always @(posedge i_clock) begin
        stage_reg <= {stage_reg[1:0], i_level};
        o_pin <= i_slow ? stage_reg[2] : i_level;
    end
endmodule
`default_nettype wire

// ===== sim/cpo_power_on_ctrl_bench.sv
// Self-checking bench for the channel A power-on control block.
`timescale 1ns/1ns
`default_nettype none
module cpo_power_on_ctrl_bench
    import cpo_pkg::*;
;
    localparam int D50 = 5;
    localparam int D250 = 9;
    localparam int D1S = 13;
    localparam logic [ADDR_W-1:0] A_SET = {IDX_SETTING, 2'b00};
    localparam logic [ADDR_W-1:0] A_ST = {IDX_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] A_BAD = 18'h00008;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic host_level = 1'b0;
    logic slow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin, enable, en_prev;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [40:0] q_b[$], q_r[$], q_en[$];
    logic [7:0] cfg = 8'h00;
    logic pin_lvl = 1'b0;
    logic cur = 1'b0;
    logic [31:0] rnd = 32'h5BA3;
    int cyc = 0;
    int last_b = 0;
    int num_errors = 0;
    int check_count = 0;

    cpo_host_model u_host (.i_clock(i_clock), .i_level(host_level), .i_slow(slow), .o_pin(pin));

    cpo_power_on_ctrl #(.P_DLY_50MS_CYCLES(D50), .P_DLY_250MS_CYCLES(D250),
        .P_DLY_1S_CYCLES(D1S)) u_dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
        .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
        .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
        .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
        .i_channel_a_power_on_request(pin), .o_channel_a_enable(enable));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and a free edge counter that stamps every observed enable edge.
    initial begin
        forever #50 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
    end

    task automatic stop_test;
        $display("Errors: %0d, checks: %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [40:0] seen, input logic [40:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // A wait that used up its bound counts as a mismatch and ends the run.
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            stop_test;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitor: every response or enable edge takes the oldest note of its kind.
    // An edge with no note pending compares against all ones and so fails.
    always @(posedge i_clock) begin
        en_prev <= enable;
        if (bvalid && bready) begin
            check(bresp, q_b.size() ? q_b.pop_front() : '1);
        end
        if (rvalid && rready) begin
            check({rresp, rdata}, q_r.size() ? q_r.pop_front() : '1);
        end
        if (i_rst_b && enable !== en_prev) begin
            check({enable, cyc}, q_en.size() ? q_en.pop_front() : '1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus master tasks: valids held until taken, ready held until the answer.
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d,
        input logic [3:0] s, input logic [1:0] r);
        int n;
        @(posedge i_clock);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        q_b.push_back({39'h0, r});
        for (n = 0; n < 50 && !(bvalid && bready); n++) begin
            @(posedge i_clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        bound(n, 50);
        bready <= 1'b0;
        last_b = cyc;
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [7:0] d,
        input logic [1:0] r);
        int n;
        @(posedge i_clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        q_r.push_back({7'h0, r, 24'h0, d});
        for (n = 0; n < 50 && !(rvalid && rready); n++) begin
            @(posedge i_clock);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        bound(n, 50);
        rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reference model of the effective request and of the delay lengths.
    // request selection model.
    function automatic logic eff_of(input logic [7:0] c, input logic p);
        case (c[SEL_HI:SEL_LO])
            SEL_ALWAYS_ON: return 1'b1;
            SEL_PIN: return p ^ c[BIT_POLARITY];
            SEL_SOFTWARE: return c[BIT_SW_REQUEST];
            default: return (p ^ c[BIT_POLARITY]) & c[BIT_SW_REQUEST];
        endcase
    endfunction

    // Random source: one step of a 32-bit linear feedback shift register.
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic int dly(input logic [1:0] k);
        return k == DLY_0MS ? 1 : k == DLY_50MS ? D50 : k == DLY_250MS ? D250 : D1S;
    endfunction

    task automatic upd(input int base);
        logic e;
        e = eff_of(cfg, pin_lvl);
        if (e !== cur) q_en.push_back({8'h0, e, 32'(base + 1 + dly(e ? cfg[3:2] : cfg[1:0]))});
        cur = e;
    endtask

    task automatic wait_idle;
        int n;
        for (n = 0; n < 100 && q_en.size() > 0; n++) @(posedge i_clock);
        bound(n, 100);
    endtask

    task automatic wr_cfg(input logic [7:0] c);
        axi_write(A_SET, c, 4'hF, RESP_OKAY);
        cfg = c;
        upd(last_b);
        wait_idle;
        axi_read(A_SET, c, RESP_OKAY);
    endtask

    // The pin reaches the block one cycle after the command, three more when slow.
    task automatic set_pin(input logic l);
        int n;
        @(posedge i_clock);
        host_level <= l;
        pin_lvl = l;
        upd(cyc + 4 + (slow ? 3 : 0));
        for (n = 0; n < 20 && pin !== l; n++) @(posedge i_clock);
        bound(n, 20);
        repeat (3) @(posedge i_clock);
        wait_idle;
    endtask

    // A short pulse against the settled level; the 250 ms delay must pass quietly.
    task automatic glitch(input logic l);
        @(posedge i_clock);
        host_level <= l;
        repeat (4) @(posedge i_clock);
        host_level <= pin_lvl;
        repeat (20) @(posedge i_clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        int k;
        repeat (5) @(posedge i_clock);
        i_rst_b <= 1'b1;
        q_en.push_back({8'h0, 1'b1, 32'(cyc + 3)});
        cur = 1'b1;
        wait_idle;
        axi_read(A_SET, SETTING_RESET, RESP_OKAY);
        wr_cfg(8'hC0);
        set_pin(1'b1);
        set_pin(1'b0);
        // both polarities, prompt and slow host.
        for (k = 0; k < 4; k++) begin
            slow <= k[1];
            wr_cfg({k[0], 1'b1, 2'b01, 4'h0});
            set_pin(1'b1);
            set_pin(1'b0);
        end
        slow <= 1'b0;
        // every delay code, polarity set but unused.
        for (k = 0; k < 4; k++) begin
            wr_cfg({2'b11, 2'b10, k[1:0], k[1:0]});
            set_pin(~pin_lvl);
            wr_cfg({2'b10, 2'b10, k[1:0], k[1:0]});
        end
        for (k = 0; k < 4; k++) begin
            wr_cfg({1'b0, k[0], 2'b11, 4'h0});
            set_pin(k[1]);
        end
        set_pin(1'b0);
        wr_cfg(8'h18);
        glitch(1'b1);
        set_pin(1'b1);
        wr_cfg(8'h12);
        glitch(1'b0);
        set_pin(1'b0);
        // Random settings and pin levels.
        for (k = 0; k < 8; k++) begin
            rnd = lfsr_next(rnd);
            wr_cfg(rnd[7:0]);
            set_pin(rnd[9]);
        end
        // Read-only, masked, and unmapped accesses leave the setting alone.
        axi_write(A_ST, 8'hFF, 4'hF, RESP_OKAY);
        axi_write(A_SET, ~cfg, 4'hE, RESP_OKAY);
        axi_write(A_BAD, 8'h5A, 4'hF, RESP_SLVERR);
        axi_read(A_BAD, 8'h00, RESP_SLVERR);
        axi_read(A_SET, cfg, RESP_OKAY);
        axi_read(A_ST, {5'h0, cur, cur, pin_lvl}, RESP_OKAY);
        repeat (3) @(posedge i_clock);
        stop_test;
    end
endmodule
`default_nettype wire
